// file: dv/afcpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module afcpc_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hard_powerdown_in_n,
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic        status_n,
    input wire logic        converting,
    input wire logic        core_on,
    input wire logic        ref_on,
    input wire logic        fifo_data_valid,
    input wire logic [3:0]  fifo_level,
    input wire logic [11:0] config_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Threshold in force: single shot always uses one entry
    wire logic [3:0] thr = (config_reg[6:5] == 2'b00) ? 4'h1
                         : 4'h8 - {1'b0, config_reg[1:0], 1'b0};
    sequence s_rd;
        cmd_valid && cmd_word[15:12] == 4'hE;
    endsequence
    a_level_bound: assert property (fifo_level <= 4'h8)
        else $error("queue level above depth");
    a_int_at_thr: assert property (
        fifo_level == thr && fifo_level > $past(fifo_level) && !cmd_valid
        && hard_powerdown_in_n && !(config_reg[6:5] == 2'b00 && config_reg[8])
        |=> !status_n) else $error("interrupt missed at threshold");
    a_rd_pops: assert property (s_rd ##0 fifo_level != 4'h0
        |=> fifo_data_valid && fifo_level <= $past(fifo_level))
        else $error("read of filled queue gave no data");
    a_rd_empty: assert property (s_rd ##0 fifo_level == 4'h0
        |=> !fifo_data_valid) else $error("read of empty queue gave data");
    a_cfg_write: assert property (
        cmd_valid && cmd_word[15:12] == 4'hA
        |=> config_reg == $past(cmd_word[11:0]))
        else $error("configuration write lost");
    a_soft_pd: assert property (
        cmd_valid && cmd_word == 16'h8000
        |=> !ref_on && !core_on && fifo_level == 4'h0)
        else $error("software power-down incomplete");
    a_hard_pd: assert property ($fell(hard_powerdown_in_n)
        |-> ##[1:6] (!ref_on && !core_on && fifo_level == 4'h0))
        else $error("hardware power-down incomplete");
    a_conv_end: assert property ($fell(converting) |-> !core_on)
        else $error("core left on after conversion");
endmodule // afcpc_checker
bind afcpc_top afcpc_checker u_chk (.clk(clk), .rst(rst),
    .hard_powerdown_in_n(hard_powerdown_in_n), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .status_n(status_n), .converting(converting),
    .core_on(core_on), .ref_on(ref_on), .fifo_data_valid(fifo_data_valid),
    .fifo_level(fifo_level), .config_reg(config_reg));
`default_nettype wire

// file: dv/afcpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module afcpc_host_model (
    input  wire logic clk,
    output var logic  sclk,
    output var logic  cs_n
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // Serial clock only runs while the host asks for it
    task automatic tick(input int n);
        repeat (n)
        begin
            repeat (17) @(posedge clk);
            sclk <= 1'b1;
            repeat (17) @(posedge clk);
            sclk <= 1'b0;
        end
    endtask
    task automatic frame();
        @(posedge clk);
        cs_n <= 1'b0;
        tick(6);
        cs_n <= 1'b1;
        #1;
    endtask
endmodule // afcpc_host_model
`default_nettype wire

// file: dv/tb_afcpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_afcpc_top;
    logic        clk = 1'b0, rst = 1'b1, osc = 1'b0, pd_n = 1'b1, cv = 1'b0;
    logic [15:0] cw = 16'h0000;
    logic [13:0] raw = 14'h0000;
    logic        sclk, cs_n, st_n, conv, c_on, r_on, r_rdy, dv;
    logic [11:0] fd, cfg;
    logic [3:0]  lvl;
    logic [2:0]  ch;
    logic        cst_n = 1'b1, smp, rx, r4;
    int          error_cnt = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    always #12.5 osc = ~osc;
    afcpc_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n));
    afcpc_top #(.WARMUP_CYCLES(16)) u_dut (.clk(clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .frame_sync_in(1'b1),
        .conversion_start_in_n(cst_n), .hard_powerdown_in_n(pd_n),
        .internal_osc(osc), .cmd_valid(cv), .cmd_word(cw),
        .sweep_list(12'h000), .sample_raw(raw), .status_n(st_n),
        .sampling(smp), .converting(conv), .channel(ch), .core_on(c_on),
        .ref_on(r_on), .ref_ready(r_rdy), .ref_external(rx), .ref_4v(r4),
        .fifo_data(fd), .fifo_data_valid(dv), .fifo_level(lvl),
        .config_reg(cfg));
    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmd(input logic [15:0] w);
        @(posedge clk);
        cv <= 1'b1;
        cw <= w;
        @(posedge clk);
        cv <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] exp);
        cmd(16'hE000);
        chk("fifo_data", 16'(fd), 16'(exp));
        chk("data_valid", 16'(dv), 16'h0001);
    endtask
    task automatic wait_lvl(input logic [3:0] lv);
        for (int n = 0; n < 4000 && lvl !== lv; n++)
        begin
            @(posedge clk);
            #1;
        end
        if (lvl !== lv)
        begin
            chk("fifo_level", 16'(lvl), 16'(lv));
            summarize();
        end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("status_n", 16'(st_n), 16'h0001);
        chk("ref_ready", 16'(r_rdy), 16'h0000);
        repeat (20) @(posedge clk);
        #1;
        chk("ref_ready", 16'(r_rdy), 16'h0001);
        cmd(16'hA023);
        cmd(16'h3000);
        raw <= 14'h0123;
        u_host.frame();
        wait_lvl(4'h1);
        chk("channel", 16'(ch), 16'h0003);
        chk("status_n", 16'(st_n), 16'h0001);
        raw <= 14'h2000;
        u_host.frame();
        wait_lvl(4'h2);
        @(posedge clk);
        #1;
        chk("status_n", 16'(st_n), 16'h0000);
        rd(12'h123);
        rd(12'h000);
        cmd(16'hE000);
        chk("data_valid", 16'(dv), 16'h0000);
        chk("status_n", 16'(st_n), 16'h0001);
        u_host.frame();
        wait_lvl(4'h1);
        u_host.frame();
        wait_lvl(4'h2);
        cmd(16'h3000);
        chk("fifo_level", 16'(lvl), 16'h0000);
        for (int d = 0; d < 3; d++)
        begin
            cmd(16'hA004 | 16'(d << 3));
            raw <= 14'h1ABC;
            u_host.frame();
            u_host.tick(13 << d);
            repeat (8) @(posedge clk);
            #1;
            chk("converting", 16'(conv), 16'h0001);
            u_host.tick(1 << d);
            repeat (8) @(posedge clk);
            #1;
            chk("converting", 16'(conv), 16'h0000);
            chk("status_n", 16'(st_n), 16'h0000);
            rd(12'hFFF);
            chk("status_n", 16'(st_n), 16'h0001);
        end
        cmd(16'hA180);
        cst_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("sampling", 16'(smp), 16'h0001);
        cst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("status_n", 16'(st_n), 16'h0000);
        wait_lvl(4'h1);
        chk("status_n", 16'(st_n), 16'h0001);
        rd(12'hFFF);
        cmd(16'hA600);
        u_host.frame();
        wait_lvl(4'h1);
        cmd(16'h8000);
        chk("fifo_level", 16'(lvl), 16'h0000);
        chk("ref_on", 16'(r_on), 16'h0000);
        chk("config_reg", 16'(cfg), 16'h0600);
        chk("ref_sel", 16'({rx, r4}), 16'h0003);
        u_host.frame();
        chk("ref_ready", 16'(r_rdy), 16'h0001);
        u_host.frame();
        wait_lvl(4'h1);
        pd_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("fifo_level", 16'(lvl), 16'h0000);
        chk("ref_on", 16'(r_on), 16'h0000);
        pd_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("ref_on", 16'(r_on), 16'h0001);
        summarize();
    end
endmodule // tb_afcpc_top
`default_nettype wire

// file: rtl/afcpc_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module afcpc_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 8,
    parameter int CNT_W = 4
) (
    input  wire logic   clk,
    input  wire logic   rst,
    afcpc_fifo_if.queue f
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH || CNT_W < PW + 1)
    begin : g_bad
        $error("afcpc_fifo: DEPTH must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [CNT_W-1:0]        cnt;
    } afcpc_fifo_s;

    afcpc_fifo_s q_ff;
    afcpc_fifo_s nxt_q;

    logic do_push;
    logic do_pop;

    assign f.rdata = q_ff.mem[q_ff.rd];
    assign f.count = q_ff.cnt;
    assign f.full  = (q_ff.cnt == CNT_W'(DEPTH));
    assign f.empty = (q_ff.cnt == '0);

    always_comb
    begin
        nxt_q   = q_ff;
        do_pop  = f.pop && !f.empty;
        do_push = f.push && (!f.full || do_pop);
        if (do_push)
        begin
            nxt_q.mem[q_ff.wr] = f.wdata;
            nxt_q.wr           = q_ff.wr + PW'(1);
        end
        if (do_pop)
        begin
            nxt_q.rd = q_ff.rd + PW'(1);
        end
        if (do_push && !do_pop)
        begin
            nxt_q.cnt = q_ff.cnt + CNT_W'(1);
        end
        else if (do_pop && !do_push)
        begin
            nxt_q.cnt = q_ff.cnt - CNT_W'(1);
        end
        if (f.flush)
        begin
            nxt_q.wr  = '0;
            nxt_q.rd  = '0;
            nxt_q.cnt = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

endmodule // afcpc_fifo

`default_nettype wire

// file: rtl/afcpc_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface afcpc_fifo_if #(
    parameter int W     = 12,
    parameter int CNT_W = 4
);
    logic             push;
    logic [W-1:0]     wdata;
    logic             pop;
    logic             flush;
    logic [W-1:0]     rdata;
    logic [CNT_W-1:0] count;
    logic             full;
    logic             empty;

    modport ctrl  (output push, wdata, pop, flush,
                   input  rdata, count, full, empty);
    modport queue (input  push, wdata, pop, flush,
                   output rdata, count, full, empty);
endinterface

`default_nettype wire

// file: rtl/afcpc_pkg.sv
package afcpc_pkg;

    // ----------------------------------------------------------------
    // Result queue
    // ----------------------------------------------------------------
    localparam int          FIFO_DEPTH   = 8;
    localparam int          RES_W        = 12;
    localparam int          RAW_W        = 14;
    localparam int          CNT_W        = 4;
    localparam logic [11:0] RES_MAX      = 12'hFFF;
    localparam logic [3:0]  THR_SINGLE   = 4'h1;
    localparam logic [3:0]  THR_FULL     = 4'h8;
    localparam logic [3:0]  THR_3Q       = 4'h6;
    localparam logic [3:0]  THR_HALF     = 4'h4;
    localparam logic [3:0]  THR_QUARTER  = 4'h2;

    // ----------------------------------------------------------------
    // Configuration register layout
    // ----------------------------------------------------------------
    localparam int          CFG_W          = 12;
    localparam logic [11:0] CFG_RESET      = 12'h000;
    localparam int          CFG_THR_LSB    = 0;
    localparam int          CFG_CLKSRC_BIT = 2;
    localparam int          CFG_DIV_LSB    = 3;
    localparam int          CFG_MODE_LSB   = 5;
    localparam int          CFG_EXTSMP_BIT = 7;
    localparam int          CFG_EOCSEL_BIT = 8;
    localparam int          CFG_REFEXT_BIT = 9;
    localparam int          CFG_REF4V_BIT  = 10;

    localparam logic [1:0]  DIV_1 = 2'h0;
    localparam logic [1:0]  DIV_2 = 2'h1;
    localparam logic [1:0]  DIV_4 = 2'h2;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_REPEAT = 2'b01,
        MODE_SWEEP  = 2'b10,
        MODE_RSWEEP = 2'b11
    } afcpc_mode_e;

    // ----------------------------------------------------------------
    // Serial command words
    // ----------------------------------------------------------------
    localparam logic [15:0] SOFT_PD_WORD = 16'h8000;
    localparam logic [3:0]  CMD_CFG_WR   = 4'hA;
    localparam logic [3:0]  CMD_FIFO_RD  = 4'hE;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam logic [3:0]  CONV_CLKS     = 4'hE;
    localparam int          CLK_MHZ       = 200;
    localparam int          WARMUP_MS     = 20;
    localparam int          WARMUP_CYCLES = WARMUP_MS * CLK_MHZ * 1000;
    localparam int          WARM_W        = 23;

    // ----------------------------------------------------------------
    // Pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int PIN_N    = 6;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS   = 1;
    localparam int PIN_FS   = 2;
    localparam int PIN_CST  = 3;
    localparam int PIN_HARD_POWERDOWN_IN = 4;
    localparam int PIN_OSC  = 5;

endpackage

// file: rtl/afcpc_top.sv
// What this block does
// [R1] Results queue eight deep with a configurable fill threshold.
// [R2] Interrupt asserts once queued results reach the programmed threshold.
// [R3] Queue takes one fixed channel or a sweep sequence, in conversion order.
// [R4] Single shot uses a threshold of one and ignores threshold bits.
// [R5] Conversion takes 14 conversion clocks; oscillator is at least 3.6 MHz.
// [R6] Serial clock as conversion clock is divided by one, two or four.
// [R7] Host keeps the divided serial clock at or below 6 MHz.
// [R8] After each conversion enter auto low power, reference stays on.
// [R9] Chip select, frame sync or start wakes from auto low power promptly; here start wakes only with extended sampling, else chip select or frame sync.
// [R10] Writing 8000h powers down everything, reference included.
// [R11] Power-down input low powers down; releasing it wakes the device.
// [R12] Soft power-down wakes on activity; internal reference warms 20 ms.
// [R13] Power-down keeps configuration; sweep restarts at first channel.
// [R14] Entering any power-down empties the result queue.
// [R15] Host holds select cycles at least six serial clocks long.
// [R16] Extended sampling: start low time outside chip select low is sampling.
// [R17] Configuration picks internal 2 V or 4 V reference, or external.
// [R18] Output code clamps to full scale above and zero below range.
// [R19] End-of-conversion status option only in single shot; else interrupt.
// [R20] Repeat modes: interrupt served without reading clears the queue.
// [R21] Interrupt releases after reading up to threshold or a new command.
`timescale 1ns/1ps
`default_nettype none

module afcpc_top #(
    parameter int WARMUP_CYCLES = afcpc_pkg::WARMUP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        frame_sync_in,
    input  wire logic        conversion_start_in_n,
    input  wire logic        hard_powerdown_in_n,
    input  wire logic        internal_osc,
    input  wire logic        cmd_valid,
    input  wire logic [15:0] cmd_word,
    input  wire logic [11:0] sweep_list,
    input  wire logic [13:0] sample_raw,
    output logic             status_n,
    output logic             sampling,
    output logic             converting,
    output logic [2:0]       channel,
    output logic             core_on,
    output logic             ref_on,
    output logic             ref_ready,
    output logic             ref_external,
    output logic             ref_4v,
    output logic [11:0]      fifo_data,
    output logic             fifo_data_valid,
    output logic [3:0]       fifo_level,
    output logic [11:0]      config_reg
);
    localparam int WW = afcpc_pkg::WARM_W;

    if (WARMUP_CYCLES < 1 || WARMUP_CYCLES >= (1 << WW))
    begin : g_bad_warm
        $error("afcpc_top: WARMUP_CYCLES out of range");
    end

    typedef enum logic [2:0] {
        ST_HARD_PD = 3'b000,
        ST_SOFT_PD = 3'b001,
        ST_AUTO_PD = 3'b010,
        ST_SAMPLE  = 3'b011,
        ST_CONVERT = 3'b100
    } afcpc_state_e;

    typedef struct packed {
        logic [afcpc_pkg::PIN_N-1:0] sync1;
        logic [afcpc_pkg::PIN_N-1:0] sync2;
        logic [afcpc_pkg::PIN_N-1:0] prev;
        afcpc_state_e                state;
        logic [11:0]                 cfg;
        logic [2:0]                  fixed_ch;
        logic [2:0]                  channel;
        logic [1:0]                  sweep_step;
        logic [1:0]                  div_cnt;
        logic [3:0]                  conv_cnt;
        logic                        int_pending;
        logic [3:0]                  reads;
        logic                        status_n;
        logic                        sampling;
        logic                        converting;
        logic                        core_on;
        logic                        ref_on;
        logic                        ref_ready;
        logic [WW-1:0]               warm_cnt;
        logic [11:0]                 rd_data;
        logic                        rd_valid;
    } afcpc_top_s;

    afcpc_top_s q_ff;
    afcpc_top_s nxt_q;

    afcpc_fifo_if #(.W(afcpc_pkg::RES_W), .CNT_W(afcpc_pkg::CNT_W)) fq ();

    afcpc_fifo #(
        .W     (afcpc_pkg::RES_W),
        .DEPTH (afcpc_pkg::FIFO_DEPTH),
        .CNT_W (afcpc_pkg::CNT_W)
    ) u_fifo (
        .clk (clk),
        .rst (rst),
        .f   (fq.queue)
    );

    // ----------------------------------------------------------------
    // Clamp of the raw converter code
    // ----------------------------------------------------------------
    function automatic logic [11:0] clamp(input logic [13:0] raw);
        logic [11:0] r;
        r = raw[11:0];
        if (raw[13])
        begin
            r = '0; // [R18]
        end
        else if (raw[12])
        begin
            r = afcpc_pkg::RES_MAX; // [R18]
        end
        return r;
    endfunction

    logic [afcpc_pkg::PIN_N-1:0] fall;
    logic [afcpc_pkg::PIN_N-1:0] rise;
    logic [1:0]                  mode;
    logic [3:0]                  thr;
    logic                        tick;
    logic                        wake;
    logic                        ext_smp;
    logic                        cs_hi;
    logic                        repeat_mode;

    always_comb
    begin
        nxt_q       = q_ff;
        nxt_q.sync1 = {internal_osc, hard_powerdown_in_n,
                       conversion_start_in_n, frame_sync_in, cs_n, sclk};
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.prev  = q_ff.sync2;
        fall        = q_ff.prev & ~q_ff.sync2;
        rise        = ~q_ff.prev & q_ff.sync2;
        mode        = q_ff.cfg[afcpc_pkg::CFG_MODE_LSB +: 2];
        ext_smp     = q_ff.cfg[afcpc_pkg::CFG_EXTSMP_BIT];
        cs_hi       = q_ff.sync2[afcpc_pkg::PIN_CS];
        repeat_mode = (mode == afcpc_pkg::MODE_REPEAT)
                   || (mode == afcpc_pkg::MODE_RSWEEP);
        wake        = fall[afcpc_pkg::PIN_CS] | fall[afcpc_pkg::PIN_FS]
                    | fall[afcpc_pkg::PIN_CST];
        nxt_q.rd_valid = 1'b0;
        fq.push  = 1'b0;
        fq.pop   = 1'b0;
        fq.flush = 1'b0;
        fq.wdata = clamp(sample_raw);

        // ------------------------------------------------------------
        // Threshold
        // ------------------------------------------------------------
        case (q_ff.cfg[afcpc_pkg::CFG_THR_LSB +: 2])
            2'b00:   thr = afcpc_pkg::THR_FULL;   // [R1]
            2'b01:   thr = afcpc_pkg::THR_3Q;
            2'b10:   thr = afcpc_pkg::THR_HALF;
            default: thr = afcpc_pkg::THR_QUARTER;
        endcase
        if (mode == afcpc_pkg::MODE_SINGLE)
        begin
            thr = afcpc_pkg::THR_SINGLE; // [R4]
        end

        // ------------------------------------------------------------
        // Conversion clock
        // ------------------------------------------------------------
        if (rise[afcpc_pkg::PIN_SCLK])
        begin
            nxt_q.div_cnt = q_ff.div_cnt + 2'h1;
        end
        if (q_ff.cfg[afcpc_pkg::CFG_CLKSRC_BIT])
        begin
            case (q_ff.cfg[afcpc_pkg::CFG_DIV_LSB +: 2])
                afcpc_pkg::DIV_1: tick = rise[afcpc_pkg::PIN_SCLK]; // [R6]
                afcpc_pkg::DIV_2: tick = rise[afcpc_pkg::PIN_SCLK]
                                      && q_ff.div_cnt[0];          // [R6]
                default:          tick = rise[afcpc_pkg::PIN_SCLK]
                                      && (q_ff.div_cnt == 2'h3);   // [R6]
            endcase
        end
        else
        begin
            tick = rise[afcpc_pkg::PIN_OSC];
        end

        // ------------------------------------------------------------
        // Reference warm-up
        // ------------------------------------------------------------
        if (q_ff.ref_on && !q_ff.ref_ready)
        begin
            nxt_q.warm_cnt = q_ff.warm_cnt + 23'h00_0001;
            if (q_ff.cfg[afcpc_pkg::CFG_REFEXT_BIT]
                || q_ff.warm_cnt == WW'(WARMUP_CYCLES - 1))
            begin
                nxt_q.ref_ready = 1'b1; // [R12]
            end
        end

        // ------------------------------------------------------------
        // Power and conversion sequencing
        // ------------------------------------------------------------
        case (q_ff.state)
            ST_HARD_PD:
            begin
                if (q_ff.sync2[afcpc_pkg::PIN_HARD_POWERDOWN_IN])
                begin
                    nxt_q.state    = ST_AUTO_PD; // [R11]
                    nxt_q.ref_on   = 1'b1;
                    nxt_q.warm_cnt = '0;
                end
            end
            ST_SOFT_PD:
            begin
                if (wake)
                begin
                    nxt_q.state    = ST_AUTO_PD; // [R12]
                    nxt_q.ref_on   = 1'b1;
                    nxt_q.warm_cnt = '0;
                end
            end
            ST_AUTO_PD:
            begin
                if (ext_smp ? (fall[afcpc_pkg::PIN_CST] && cs_hi)
                            : (fall[afcpc_pkg::PIN_CS]
                               || fall[afcpc_pkg::PIN_FS]))
                begin
                    nxt_q.state   = ST_SAMPLE; // [R9]
                    nxt_q.core_on = 1'b1;
                    nxt_q.channel = (mode[1])
                        ? sweep_list[q_ff.sweep_step*3 +: 3]
                        : q_ff.fixed_ch; // [R3]
                end
            end
            ST_SAMPLE:
            begin
                if (ext_smp ? rise[afcpc_pkg::PIN_CST]
                            : rise[afcpc_pkg::PIN_CS])
                begin
                    nxt_q.state    = ST_CONVERT;
                    nxt_q.conv_cnt = '0;
                end
            end
            ST_CONVERT:
            begin
                if (tick)
                begin
                    nxt_q.conv_cnt = q_ff.conv_cnt + 4'h1;
                    if (q_ff.conv_cnt == afcpc_pkg::CONV_CLKS - 4'h1)
                    begin
                        fq.push          = 1'b1;       // [R5] [R3]
                        nxt_q.sweep_step = q_ff.sweep_step + 2'h1;
                        nxt_q.state      = ST_AUTO_PD; // [R8]
                        nxt_q.core_on    = 1'b0;       // [R8]
                    end
                end
            end
            default:
            begin
                nxt_q.state = ST_AUTO_PD;
            end
        endcase
        nxt_q.sampling = (nxt_q.state == ST_SAMPLE)
                      && !(ext_smp && !cs_hi); // [R16]

        // ------------------------------------------------------------
        // Commands
        // ------------------------------------------------------------
        if (cmd_valid)
        begin
            if (cmd_word[15:12] == afcpc_pkg::CMD_FIFO_RD)
            begin
                if (!fq.empty)
                begin
                    fq.pop         = 1'b1;
                    nxt_q.rd_data  = fq.rdata;
                    nxt_q.rd_valid = 1'b1;
                    nxt_q.reads    = q_ff.reads + 4'h1;
                    if (q_ff.int_pending && q_ff.reads + 4'h1 >= thr)
                    begin
                        nxt_q.int_pending = 1'b0; // [R21]
                        nxt_q.reads       = '0;
                    end
                end
            end
            else
            begin
                if (q_ff.int_pending)
                begin
                    nxt_q.int_pending = 1'b0; // [R21]
                    if (repeat_mode && q_ff.reads == '0)
                    begin
                        fq.flush = 1'b1; // [R20]
                    end
                end
                nxt_q.reads = '0;
                if (cmd_word == afcpc_pkg::SOFT_PD_WORD)
                begin
                    nxt_q.state     = ST_SOFT_PD; // [R10]
                    nxt_q.core_on   = 1'b0;
                    nxt_q.ref_on    = 1'b0;       // [R10]
                    nxt_q.ref_ready = 1'b0;
                    nxt_q.sampling  = 1'b0;
                    nxt_q.sweep_step = '0;        // [R13]
                    fq.flush        = 1'b1;       // [R14]
                end
                else if (cmd_word[15:12] == afcpc_pkg::CMD_CFG_WR)
                begin
                    nxt_q.cfg = cmd_word[11:0]; // [R17]
                end
                else if (!cmd_word[15])
                begin
                    nxt_q.fixed_ch = cmd_word[14:12];
                end
            end
        end

        // Set wins over a release unless the queue is flushed; a popping read defers it a cycle
        if (!nxt_q.int_pending && !fq.flush
            && fq.count >= thr && q_ff.state != ST_SOFT_PD && !fq.pop)
        begin
            nxt_q.int_pending = 1'b1; // [R2]
        end

        // ------------------------------------------------------------
        // Hardware power-down overrides everything
        // ------------------------------------------------------------
        if (!q_ff.sync2[afcpc_pkg::PIN_HARD_POWERDOWN_IN])
        begin
            nxt_q.state       = ST_HARD_PD; // [R11]
            nxt_q.core_on     = 1'b0;
            nxt_q.ref_on      = 1'b0;
            nxt_q.ref_ready   = 1'b0;
            nxt_q.sampling    = 1'b0;
            nxt_q.int_pending = 1'b0;
            nxt_q.reads       = '0;
            nxt_q.sweep_step  = '0;   // [R13]
            fq.flush          = 1'b1; // [R14]
        end

        nxt_q.converting = (nxt_q.state == ST_CONVERT);
        nxt_q.status_n = (mode == afcpc_pkg::MODE_SINGLE
                          && q_ff.cfg[afcpc_pkg::CFG_EOCSEL_BIT])
                       ? (nxt_q.state != ST_CONVERT)
                       : !nxt_q.int_pending; // [R19]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_ff          <= '0;
            q_ff.state    <= ST_AUTO_PD;
            q_ff.cfg      <= afcpc_pkg::CFG_RESET;
            q_ff.sync1    <= '1;
            q_ff.sync2    <= '1;
            q_ff.prev     <= '1;
            q_ff.status_n <= 1'b1;
            q_ff.ref_on   <= 1'b1;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign status_n        = q_ff.status_n;
    assign sampling        = q_ff.sampling;
    assign converting      = q_ff.converting;
    assign channel         = q_ff.channel;
    assign core_on         = q_ff.core_on;
    assign ref_on          = q_ff.ref_on;
    assign ref_ready       = q_ff.ref_ready;
    assign ref_external    = q_ff.cfg[afcpc_pkg::CFG_REFEXT_BIT];
    assign ref_4v          = q_ff.cfg[afcpc_pkg::CFG_REF4V_BIT];
    assign fifo_data       = q_ff.rd_data;
    assign fifo_data_valid = q_ff.rd_valid;
    assign fifo_level      = fq.count;
    assign config_reg      = q_ff.cfg;

endmodule // afcpc_top

`default_nettype wire
